/* logic/cfim_top.sv */
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - Flags register is 8 bits; bits 6 and 5 always read one.
// - Overflow flag follows two's complement overflow of add, add-with-carry and subtract; logic clears it, decimal adjust keeps it.
// - Signed branches greater, greater-equal, less-equal, less use overflow.
// - Add and add-with-carry set half-carry on carry from bit 3.
// - Decimal adjust picks correction from half-carry and carry flags, or from a low digit above 9 or a byte above 99h.
// - Mask set blocks maskable interrupts; mask clear accepts them.
// - Interrupt entry stacks registers, then sets mask, then fetches vector.
// - Entry does not stack high index byte; software pushes and pops it.
// - On unmask, the highest priority pending request is serviced first.
// - Interrupt return pops registers and restores mask from the stack.
// - Reset sets the mask; only the unmask instruction or an interrupt return of a clear stacked mask clears it.
// - Negative flag equals bit 7 of the result.
module cfim_top
   import cfim_pkg::*;
(
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [3:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic [NUM_IRQ-1:0] irq_req_in,
   output logic [7:0] stack_data_out,
   output logic stack_push_out,
   output logic vector_fetch_out,
   output logic [1:0] vector_sel_out
);
   cfim_alu_if alu_bus ();
   logic [7:0] flags_q;
   logic [7:0] flags_d;
   logic [7:0] acc_q;
   logic [7:0] opnd_q;
   logic [7:0] popped_q;
   logic [7:0] high_index_q;
   logic [7:0] high_save_q;
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;
   logic ack_q;
   logic req;
   logic wr_op;
   logic take_irq;
   logic branch_taken_q;
   logic [3:0] br_hits;
   logic [1:0] win_idx;
   logic [NUM_IRQ-1:0] irq_win;
   logic [1:0] vec_q;
   logic [2:0] stk_cnt_q;
   logic push_q;
   logic fetch_q;
   cfim_state_t state_q;
   cfim_op_t op_w;
   cfim_br_t br_w;
   logic br_valid;

   cfim_alu u_alu (
      .bus(alu_bus)
   );

   // Inputs to the flag datapath
   assign alu_bus.a = acc_q;
   assign alu_bus.b = opnd_q;
   assign alu_bus.flags = flags_q;
   assign alu_bus.op = op_w;

   // Bus decode; ack is a single-cycle pulse so requests cannot double fire
   assign req = wb_cyc_in && wb_stb_in && !ack_q;
   assign wr_op = req && wb_we_in && (wb_adr_in == REG_OP) && wb_sel_in[OPF_CODE_LANE];
   assign op_w = wr_op ? cfim_op_t'(wb_dat_in[OPF_CODE_LSB +: OPF_CODE_W]) : CFIM_OP_NONE;
   assign br_w = cfim_br_t'(wb_dat_in[OPF_BR_LSB +: OPF_BR_W]);
   assign br_valid = wr_op && wb_sel_in[OPF_BR_LANE] && wb_dat_in[OPF_BR_EVAL];
   assign wb_ack_out = ack_q;
   assign wb_dat_out = rdata_q;
   assign stack_data_out = flags_q;
   assign stack_push_out = push_q;
   assign vector_fetch_out = fetch_q;
   assign vector_sel_out = vec_q;

   // Acknowledge one cycle after the request is seen
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
         ack_q <= 1'b0;
      else
         ack_q <= req;
   end

   // Operand registers written by software
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         acc_q <= 8'h00;
         opnd_q <= 8'h00;
         popped_q <= 8'h00;
      end
      else if (req && wb_we_in && (wb_adr_in == REG_OPND))
      begin
         if (wb_sel_in[LANE_ACC])
            acc_q <= wb_dat_in[LANE_ACC*BYTE_W +: BYTE_W];
         if (wb_sel_in[LANE_OPND])
            opnd_q <= wb_dat_in[LANE_OPND*BYTE_W +: BYTE_W];
         if (wb_sel_in[LANE_POP])
            popped_q <= wb_dat_in[LANE_POP*BYTE_W +: BYTE_W];
      end
      else if (wr_op)
         acc_q <= alu_bus.result;
   end

   // Next flags: the mask only clears through the unmask op or a stacked value
   always_comb
   begin
      flags_d = alu_bus.new_flags;
      case (op_w)
         CFIM_OP_UNMASK: flags_d[CF_I] = 1'b0;
         CFIM_OP_SEI: flags_d[CF_I] = 1'b1;
         CFIM_OP_IRET: flags_d = popped_q | CF_FIXED_ONES;
         default: flags_d[CF_I] = flags_q[CF_I];
      endcase
      if (state_q == CFIM_MASK)
         flags_d[CF_I] = 1'b1;
   end

   // Flags register; updated in the issuing cycle, visible on the next
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
         flags_q <= CF_RESET;
      else
         flags_q <= flags_d | CF_FIXED_ONES;
   end

   // High index byte is kept apart: entry never stacks it
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         high_index_q <= 8'h00;
         high_save_q <= 8'h00;
      end
      else if (op_w == CFIM_OP_PUSH_HIGH)
         high_save_q <= high_index_q;
      else if (op_w == CFIM_OP_POP_HIGH)
         high_index_q <= high_save_q;
      else if (req && wb_we_in && (wb_adr_in == REG_STATUS) && wb_sel_in[LANE_HIGH])
         high_index_q <= wb_dat_in[LANE_HIGH*BYTE_W +: BYTE_W];
   end

   // Signed branch evaluation including the overflow flag
   always_comb
   begin
      br_hits[CFIM_BR_GT] = !(flags_q[CF_Z] || (flags_q[CF_N] ^ flags_q[CF_V]));
      br_hits[CFIM_BR_GE] = !(flags_q[CF_N] ^ flags_q[CF_V]);
      br_hits[CFIM_BR_LE] = flags_q[CF_Z] || (flags_q[CF_N] ^ flags_q[CF_V]);
      br_hits[CFIM_BR_LT] = flags_q[CF_N] ^ flags_q[CF_V];
   end

   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
         branch_taken_q <= 1'b0;
      else if (br_valid)
         branch_taken_q <= br_hits[br_w];
   end

   // Priority pick: request 0 is highest, so a request wins only while
   // every lower-numbered request is idle; the result is one-hot
   for (genvar g = 0; g < NUM_IRQ; g++)
   begin : g_prio
      if (g == 0)
      begin : g_first
         assign irq_win[g] = irq_req_in[g];
      end
      else
      begin : g_rest
         assign irq_win[g] = irq_req_in[g] && !(|irq_req_in[g-1:0]);
      end
   end

   // Encode the one-hot winner into the vector index
   always_comb
   begin
      win_idx = 2'h0;
      for (int i = 0; i < NUM_IRQ; i++)
         if (irq_win[i])
            win_idx = i[1:0];
   end

   // Acceptance only while unmasked and no instruction issues this cycle
   assign take_irq = (|irq_req_in) && !flags_q[CF_I] && !wr_op;

   // Entry sequence: stack, then mask, then vector fetch
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         state_q <= CFIM_IDLE;
         stk_cnt_q <= 3'h0;
         vec_q <= 2'h0;
      end
      else
      begin
         case (state_q)
            CFIM_IDLE:
               if (take_irq)
               begin
                  state_q <= CFIM_STACK;
                  vec_q <= win_idx;
                  stk_cnt_q <= 3'h0;
               end
            CFIM_STACK:
            begin
               stk_cnt_q <= stk_cnt_q + 3'h1;
               if (stk_cnt_q == 3'(STACK_CYCLES - 1))
                  state_q <= CFIM_MASK;
            end
            CFIM_MASK: state_q <= CFIM_VECT;
            CFIM_VECT: state_q <= CFIM_IDLE;
            default: state_q <= CFIM_IDLE;
         endcase
      end
   end

   // Registered strobes toward the stack and fetch logic
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         push_q <= 1'b0;
         fetch_q <= 1'b0;
      end
      else
      begin
         push_q <= (state_q == CFIM_STACK);
         fetch_q <= (state_q == CFIM_VECT);
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      case (wb_adr_in)
         REG_FLAGS: rdata_d[7:0] = flags_q;
         REG_OPND: rdata_d[23:0] = {popped_q, opnd_q, acc_q};
         REG_STATUS: rdata_d[15:0] = {high_index_q, 1'b0, branch_taken_q,
                                      state_q, high_save_q[3:0]};
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
         rdata_q <= 32'h0000_0000;
      else if (req && !wb_we_in)
         rdata_q <= rdata_d;
   end
endmodule

/* logic/cfim_pkg.sv */
package cfim_pkg;
   // Bit positions within the condition_flags register
   localparam int CF_C = 0;
   localparam int CF_Z = 1;
   localparam int CF_N = 2;
   localparam int CF_I = 3;
   localparam int CF_H = 4;
   localparam int CF_ONE_LO = 5;
   localparam int CF_ONE_HI = 6;
   localparam int CF_V = 7;
   localparam int CF_SIGN_BIT = 7;
   localparam int CF_NIB_BIT = 4;
   localparam int NIB_W = 4;
   // Fields of the op register write word
   localparam int OPF_CODE_LSB = 0;
   localparam int OPF_CODE_W = 4;
   localparam int OPF_CODE_LANE = 0;
   localparam int OPF_BR_LSB = 8;
   localparam int OPF_BR_W = 2;
   localparam int OPF_BR_LANE = 1;
   localparam int OPF_BR_EVAL = 12;
   // Byte lanes of the operand and status words
   localparam int BYTE_W = 8;
   localparam int LANE_ACC = 0;
   localparam int LANE_OPND = 1;
   localparam int LANE_POP = 2;
   localparam int LANE_HIGH = 1;
   // Decimal adjust limits and correction digit
   localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
   localparam logic [7:0] BCD_BYTE_MAX = 8'h99;
   localparam logic [3:0] BCD_FIX = 4'h6;
   // Reset value: mask set, fixed ones set, all other flags clear
   localparam logic [7:0] CF_RESET = 8'h68;
   localparam logic [7:0] CF_FIXED_ONES = 8'h60;
   // Wishbone register offsets (byte addresses)
   localparam logic [3:0] REG_FLAGS = 4'h0;
   localparam logic [3:0] REG_OP = 4'h4;
   localparam logic [3:0] REG_OPND = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hc;
   // Operation codes accepted by the block
   typedef enum logic [3:0] {
      CFIM_OP_NONE = 4'h0,
      CFIM_OP_ADD = 4'h1,
      CFIM_OP_ADC = 4'h2,
      CFIM_OP_SUB = 4'h3,
      CFIM_OP_LOGIC = 4'h4,
      CFIM_OP_DECADJ = 4'h5,
      CFIM_OP_UNMASK = 4'h6,
      CFIM_OP_SEI = 4'h7,
      CFIM_OP_IRET = 4'h8,
      CFIM_OP_PUSH_HIGH = 4'h9,
      CFIM_OP_POP_HIGH = 4'ha
   } cfim_op_t;
   // Branch condition codes
   typedef enum logic [1:0] {
      CFIM_BR_GT = 2'h0,
      CFIM_BR_GE = 2'h1,
      CFIM_BR_LE = 2'h2,
      CFIM_BR_LT = 2'h3
   } cfim_br_t;
   // Interrupt sequencer states, Gray coded
   typedef enum logic [1:0] {
      CFIM_IDLE = 2'b00,
      CFIM_STACK = 2'b01,
      CFIM_MASK = 2'b11,
      CFIM_VECT = 2'b10
   } cfim_state_t;
   localparam int NUM_IRQ = 4;
   localparam int STACK_CYCLES = 5;
endpackage

/* logic/cfim_alu_if.sv */
`timescale 1ns/1ps
interface cfim_alu_if;
   import cfim_pkg::*;
   logic [7:0] a;
   logic [7:0] b;
   logic [7:0] flags;
   cfim_op_t op;
   logic [7:0] result;
   logic [7:0] new_flags;
   modport core (output a, output b, output flags, output op, input result, input new_flags);
   modport alu (input a, input b, input flags, input op, output result, output new_flags);
endinterface

/* logic/cfim_alu.sv */
`timescale 1ns/1ps
module cfim_alu
   import cfim_pkg::*;
(
   cfim_alu_if.alu bus
);
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] corr;
   logic [7:0] res;
   logic cin;
   logic v;
   logic c;
   logic h;
   logic dc;

   // Arithmetic and flag results for one operation
   always_comb
   begin
      cin = (bus.op == CFIM_OP_ADC) ? bus.flags[CF_C] : 1'b0;
      nib = {1'b0, bus.a[NIB_W-1:0]} + {1'b0, bus.b[NIB_W-1:0]} + {4'h0, cin};
      sum = {1'b0, bus.a} + {1'b0, bus.b} + {8'h00, cin};
      corr = 8'h00;
      dc = bus.flags[CF_C];
      res = bus.a;
      v = bus.flags[CF_V];
      c = bus.flags[CF_C];
      h = bus.flags[CF_H];
      bus.new_flags = bus.flags;
      case (bus.op)
         CFIM_OP_ADD, CFIM_OP_ADC:
         begin
            res = sum[7:0];
            h = nib[CF_NIB_BIT];
            c = sum[8];
            v = (bus.a[CF_SIGN_BIT] == bus.b[CF_SIGN_BIT])
               && (res[CF_SIGN_BIT] != bus.a[CF_SIGN_BIT]);
         end
         CFIM_OP_SUB:
         begin
            sum = {1'b0, bus.a} - {1'b0, bus.b};
            res = sum[7:0];
            c = sum[8];
            v = (bus.a[CF_SIGN_BIT] != bus.b[CF_SIGN_BIT])
               && (res[CF_SIGN_BIT] != bus.a[CF_SIGN_BIT]);
         end
         CFIM_OP_LOGIC:
         begin
            res = bus.b;
            v = 1'b0;
         end
         CFIM_OP_DECADJ:
         begin
            // Correction picked from carry and half-carry state, or from a low digit above 9 or a byte above 0x99
            if (bus.flags[CF_H] || (bus.a[NIB_W-1:0] > BCD_DIGIT_MAX))
               corr[NIB_W-1:0] = BCD_FIX;
            if (bus.flags[CF_C] || (bus.a > BCD_BYTE_MAX))
            begin
               corr[NIB_W +: NIB_W] = BCD_FIX;
               dc = 1'b1;
            end
            res = bus.a + corr;
            c = dc;
         end
         default:
         begin
            res = bus.a;
         end
      endcase
      bus.result = res;
      if ((bus.op != CFIM_OP_NONE) && (bus.op <= CFIM_OP_DECADJ))
      begin
         bus.new_flags[CF_V] = v;
         bus.new_flags[CF_H] = h;
         bus.new_flags[CF_C] = c;
         bus.new_flags[CF_N] = res[CF_SIGN_BIT];
         bus.new_flags[CF_Z] = (res == 8'h00);
      end
      bus.new_flags = bus.new_flags | CF_FIXED_ONES;
   end
endmodule

/* bench/cfim_top_checker.sv */
`timescale 1ns/1ps
module cfim_top_checker
   import cfim_pkg::*;
(
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [3:0] wb_adr_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic wb_ack_out,
   input wire logic [NUM_IRQ-1:0] irq_req_in,
   input wire logic [7:0] stack_data_out,
   input wire logic stack_push_out,
   input wire logic vector_fetch_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);
   // Bus answers in exactly one cycle
   AST_ACK_NEXT: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("ack late");
   // Flag reads always show the fixed ones
   AST_READ_ONES: assert property (wb_ack_out && !wb_we_in && wb_adr_in == REG_FLAGS |->
      wb_dat_out[CF_ONE_HI:CF_ONE_LO] == 2'b11) else $error("fixed bits lost");
   AST_STACK_ONES: assert property ($past(rstn_in) |-> stack_data_out[6:5] == 2'b11)
      else $error("stacked fixed bits lost");
   // Entry only starts from a pending request
   AST_PUSH_CAUSE: assert property ($rose(stack_push_out) |-> $past(|irq_req_in, 2))
      else $error("entry without request");
   // Flags only, never the high index byte, so five pushes
   AST_STACK_LEN: assert property ($rose(stack_push_out) |->
      stack_push_out [*5] ##1 !stack_push_out) else $error("stack length");
   AST_MASK_SET: assert property ($fell(stack_push_out) |-> ##[0:4] stack_data_out[CF_I])
      else $error("mask not set");
   AST_FETCH_MASKED: assert property (vector_fetch_out |->
      stack_data_out[CF_I] && !stack_push_out) else $error("fetch before mask");
   AST_FETCH_SOON: assert property ($fell(stack_push_out) |-> ##[1:4] vector_fetch_out)
      else $error("no fetch");
endmodule
bind cfim_top cfim_top_checker chk_u (.clk_in(clk_in), .rstn_in(rstn_in),
   .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
   .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .irq_req_in(irq_req_in),
   .stack_data_out(stack_data_out), .stack_push_out(stack_push_out),
   .vector_fetch_out(vector_fetch_out));

/* bench/cfim_top_tb.sv */
`timescale 1ns/1ps
module cfim_top_tb;
   import cfim_pkg::*;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] dat = 32'h0;
   logic [3:0] irq = 4'h0;
   logic [3:0] sel = 4'hf;
   logic [3:0] bsel = 4'hf;
   logic [31:0] rd, wdo;
   logic [7:0] sdo, ef;
   logic ack, push, fetch;
   logic [1:0] vsel;
   int n_fail = 0;
   int cmp_count = 0;
   int cyc_n = 0;
   int pushes = 0;
   // Strobe follows cycle; byte lanes are set by the bus task from bsel
   cfim_top dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .wb_cyc_in(cyc), .wb_stb_in(cyc),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(wdo),
      .wb_ack_out(ack), .irq_req_in(irq), .stack_data_out(sdo), .stack_push_out(push),
      .vector_fetch_out(fetch), .vector_sel_out(vsel));
   initial
   begin
      forever #4 clk_in = ~clk_in;
   end
   // Watchdog and stacking-cycle count
   always @(posedge clk_in)
   begin
      cyc_n++;
      if (push === 1'b1)
         pushes++;
      if (cyc_n == 5000)
      begin
         n_fail++;
         close_out();
      end
   end
   task automatic close_out();
      if (n_fail == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: %h vs %h", $time, got, exp);
      end
   endtask
   // Ack is read at the edge, so it is the registered value of that cycle
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_in);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= bsel;
      do @(posedge clk_in); while (ack !== 1'b1);
      rd = wdo;
      cyc <= 1'b0;
   endtask
   task automatic op(input logic [3:0] c, input logic [7:0] a, input logic [7:0] b);
      bus(1'b1, REG_OPND, {16'h0, b, a});
      bus(1'b1, REG_OP, {28'h0, c});
   endtask
   // Expected flags of an add, carry-in only for add-with-carry
   function automatic logic [7:0] fl(input logic [19:0] t, input logic [7:0] f);
      logic [8:0] s;
      logic ci;
      ci = (t[19:16] == 4'h2) & f[CF_C];
      s = t[15:8] + t[7:0] + ci;
      fl = f;
      fl[CF_H] = (t[11:8] + t[3:0] + ci) > 5'h0f;
      fl[CF_V] = (t[15] == t[7]) && (s[7] != t[15]);
      fl[CF_N] = s[7];
      fl[CF_Z] = s[7:0] == 8'h00;
      fl[CF_C] = s[8];
   endfunction
   task automatic t_reset();
      rstn_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      rstn_in <= 1'b1;
      bus(1'b1, REG_FLAGS, 32'h0);
      bus(1'b0, REG_FLAGS, 32'h0);
      chk(rd, 32'h68);
      bus(1'b0, 4'h2, 32'h0);
      chk(rd, 32'h0);
      ef = CF_RESET;
   endtask
   // Flags read back right after each add, then all four signed branches
   task automatic t_add();
      logic [19:0] tc [5] = '{20'h17808, 20'h1ff01, 20'h20000, 20'h14040, 20'h2100f};
      logic [3:0] e;
      for (int i = 0; i < 5; i++)
      begin
         ef = fl(tc[i], ef);
         op(tc[i][19:16], tc[i][15:8], tc[i][7:0]);
         bus(1'b0, REG_FLAGS, 32'h0);
         chk(rd, {24'h0, ef});
         e = {ef[CF_N] ^ ef[CF_V], ef[CF_Z] | (ef[CF_N] ^ ef[CF_V]), 2'b00};
         e[1:0] = {~e[3], ~e[2]};
         for (int b = 0; b < 4; b++)
         begin
            bus(1'b1, REG_OP, {19'h0, 1'b1, 2'h0, 2'(b), 8'h0});
            bus(1'b0, REG_STATUS, 32'h0);
            chk(rd[6], e[b]);
         end
      end
   endtask
   task automatic t_daa();
      op(4'h1, 8'h09, 8'h08);
      bus(1'b1, REG_OP, 32'h5);
      bus(1'b0, REG_OPND, 32'h0);
      chk(rd[7:0], 8'h17);
      op(4'h1, 8'h90, 8'h90);
      bus(1'b1, REG_OP, 32'h5);
      bus(1'b0, REG_OPND, 32'h0);
      chk(rd[7:0], 8'h80);
   endtask
   // Subtract, load, lane select, mask ops and the high index save slot
   task automatic t_more();
      op(4'h1, 8'h00, 8'h00);
      op(4'h3, 8'h80, 8'h01);
      bus(1'b0, REG_FLAGS, 32'h0);
      chk(rd, 32'he8);
      op(4'h4, 8'h7f, 8'h80);
      bus(1'b0, REG_FLAGS, 32'h0);
      chk(rd, 32'h6c);
      bsel = 4'h2;
      bus(1'b1, REG_OPND, 32'h0055aa);
      bus(1'b1, REG_OP, 32'h1);
      bsel = 4'hf;
      bus(1'b0, REG_OPND, 32'h0);
      chk(rd, 32'h005580);
      bus(1'b1, REG_OP, 32'h6);
      bus(1'b0, REG_FLAGS, 32'h0);
      chk(rd, 32'h64);
      bus(1'b1, REG_OP, 32'h7);
      bus(1'b0, REG_FLAGS, 32'h0);
      chk(rd, 32'h6c);
      bus(1'b1, REG_STATUS, 32'ha500);
      bus(1'b1, REG_OP, 32'h9);
      bus(1'b1, REG_STATUS, 32'h3c00);
      bus(1'b1, REG_OP, 32'ha);
      bus(1'b0, REG_STATUS, 32'h0);
      chk({rd[15:8], rd[3:0]}, 12'ha55);
   endtask
   // Two requests wait behind the mask; the lower-numbered one, request 2, wins on unmask
   task automatic t_irq();
      int i;
      irq <= 4'b1100;
      repeat (20) @(posedge clk_in);
      chk(pushes, 0);
      bus(1'b1, REG_OP, 32'h6);
      i = 0;
      while (fetch !== 1'b1 && i < 40)
      begin
         @(posedge clk_in);
         i++;
      end
      chk(vsel, 2'h2);
      chk(pushes, STACK_CYCLES);
      irq <= 4'h0;
      bus(1'b0, REG_STATUS, 32'h0);
      chk(rd[15:8], 8'ha5);
      bus(1'b0, REG_FLAGS, 32'h0);
      chk(rd[CF_I], 1'b1);
      bus(1'b1, REG_OPND, 32'h600000);
      bus(1'b1, REG_OP, 32'h8);
      bus(1'b0, REG_FLAGS, 32'h0);
      chk(rd, 32'h60);
   endtask
   initial
   begin
      t_reset();
      t_add();
      t_daa();
      t_more();
      t_irq();
      t_reset();
      close_out();
   end
endmodule
